// ---- rtl/hub_strap_sampler.sv ----
// configuration strap capture and decode for a two-port hub
// Functional notes
// - capture every strap once at reset release; captured values are the defaults
// - capture after power-on reset and after each rising edge of external reset
// - strong pull-ups on both rom data-out and clock select slave-bus mode
// - no pull on rom data-out and clock selects rom master mode first
// - shared pins: rom select/in/out/clock, or the two straps plus bus data/clock
// - after capture go to soc config in slave-bus mode, else otp config
// - per port, d+ and d- disable straps captured; 1 disabled, 0 enabled
// - a port is disabled only when both its disable straps are high
// - a strap-disabled port also loses its superspeed path
// - nonremovable strap: weak down none, weak up port 1, strong down both
// - charging strap: weak down none, weak up port 1, strong down both
`include "hub_strap_regs.svh"
`timescale 1ns/100ps
module hub_strap_sampler #(
	parameter int PORTS = 2
) (
	// clock and resets
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	input  wire logic                  i_ext_rst_n,
	// strap levels from the resistor detectors
	input  wire hub_strap_pkg::level_t i_rom_data_out_level,
	input  wire hub_strap_pkg::level_t i_rom_clock_level,
	input  wire hub_strap_pkg::level_t i_nonremovable_port_strap,
	input  wire hub_strap_pkg::level_t i_charging_port_strap,
	input  wire logic [PORTS-1:0]      i_port_dplus_disable_strap,
	input  wire logic [PORTS-1:0]      i_port_dminus_disable_strap,
	// decoded configuration
	output logic                       o_cfg_valid,
	output hub_strap_pkg::pin_mode_e   o_pin_mode,
	output hub_strap_pkg::boot_next_e  o_boot_next,
	output logic [PORTS-1:0]           o_port_hs_disable,
	output logic [PORTS-1:0]           o_port_ss_disable,
	output logic [PORTS-1:0]           o_port_nonremovable,
	output logic [PORTS-1:0]           o_port_charging,
	// shared pin function selects, one hot per pin
	output logic                       o_pin41_is_rom_select,
	output logic                       o_pin40_is_rom_data_in_pin,
	output logic                       o_pin39_is_slave_bus_data_pin,
	output logic                       o_pin38_is_slave_bus_clock_pin
);
	import hub_strap_pkg::*;

	// settle window in clock cycles, rounded up from the nanosecond figure;
	// kept at one cycle at least so that a zero settle time setting still
	// leaves one counted cycle between reset release and capture
	localparam int SETTLE = (`STRAP_SETTLE_CYC < 1) ? 1 : `STRAP_SETTLE_CYC;
	localparam int CW     = $clog2(SETTLE + 1);

	typedef enum logic [1:0] {st_wait, st_settle, st_hold} phase_e;

	typedef struct packed {
		logic [1:0]       rst_sync;
		logic [1:0]       ext_sync;
		logic [PORTS-1:0] dp_s1;
		logic [PORTS-1:0] dp_s2;
		logic [PORTS-1:0] dm_s1;
		logic [PORTS-1:0] dm_s2;
		level_t [3:0]     lv_s1;
		level_t [3:0]     lv_s2;
		phase_e           phase;
		logic [CW-1:0]    cnt;
		logic             valid;
		pin_mode_e        mode;
		logic [PORTS-1:0] hs_dis;
		logic [PORTS-1:0] nonrem;
		logic [PORTS-1:0] chg;
	} state_s;

	state_s cur;
	state_s next_cur;

	// three-level strap decode, shared by the nonremovable and charging straps
	function automatic logic [PORTS-1:0] decode_ports(input level_t lvl);
		logic [PORTS-1:0] r;
		r = '0;
		case (lvl)
			`STRAP_LVL_WEAK_UP:   r[0] = 1'b1;
			`STRAP_LVL_STRONG_DN: r    = '1;
			default:              r    = '0;
		endcase
		return r;
	endfunction

	// pin function select: only live once a capture has been made
	function automatic logic pin_role(input logic vld, input pin_mode_e cur_mode,
		input pin_mode_e role);
		return vld && (cur_mode == role);
	endfunction

	// capture pipeline, edge by edge after both resets read high:
	//   edges 1-2   the reset releases walk through their two-flop chains
	//   edge 3      the sampler leaves the wait phase and clears the counter
	//   edges 4-12  the settle count runs; straps keep refilling their chains
	//   edge 13     one capture of the second sync stage
	//   edge 13     decoded settings and valid appear on the ports at that same edge
	//
	// the strap inputs are board levels, not from this clock domain, so
	// every one passes two flops (the s1 and s2 fields of the state) before
	// the capture reads it; nothing but the second stage reads the first,
	// which keeps a metastable first stage away from the decode
	//
	// the synchroniser flops live inside the state struct, so the single
	// state register below also clears them on power-on reset; a cleared
	// chain reads as weak pull-down with all lines enabled until refilled
	//
	// limitation: a strap still moving at the capture edge may be caught
	// on either side of its move; the settle window only helps if the
	// board holds its straps from the reset release onwards
	//
	// the d+ and d- chains stay apart per port, so the capture sees both
	// line straps of a port as they stood, not merged ahead of time

	// a port goes down only when both line straps read high
	logic [PORTS-1:0] both_lines_off;
	for (genvar p = 0; p < PORTS; p++) begin : g_port
		assign both_lines_off[p] = cur.dp_s2[p] & cur.dm_s2[p];
	end

	// next-state logic: wait for reset release, settle, capture once, then hold
	always_comb begin
		next_cur          = cur;
		next_cur.rst_sync = {cur.rst_sync[0], 1'b1};
		next_cur.ext_sync = {cur.ext_sync[0], i_ext_rst_n};
		// board straps walk two flops; only the second stage feeds the capture
		next_cur.dp_s1    = i_port_dplus_disable_strap;
		next_cur.dp_s2    = cur.dp_s1;
		next_cur.dm_s1    = i_port_dminus_disable_strap;
		next_cur.dm_s2    = cur.dm_s1;
		next_cur.lv_s1[0] = i_rom_data_out_level;
		next_cur.lv_s1[1] = i_rom_clock_level;
		next_cur.lv_s1[2] = i_nonremovable_port_strap;
		next_cur.lv_s1[3] = i_charging_port_strap;
		next_cur.lv_s2    = cur.lv_s1;
		case (cur.phase)
			st_wait: begin
				// leaves only once both resets are released
				if (cur.rst_sync[1] && cur.ext_sync[1]) begin
					next_cur.phase = st_settle;
					next_cur.cnt   = '0;
				end
			end
			st_settle: begin
				if (!cur.ext_sync[1]) begin
					next_cur.phase = st_wait;
				end else if (cur.cnt == CW'(SETTLE - 1)) begin
					// single capture instant
					next_cur.phase  = st_hold;
					next_cur.valid  = 1'b1;
					// both strong pull-ups mean slave bus, else rom master
					next_cur.mode   = (cur.lv_s2[0] == `STRAP_LVL_STRONG_UP &&
						cur.lv_s2[1] == `STRAP_LVL_STRONG_UP) ? mode_slave_bus : mode_rom_master;
					next_cur.hs_dis = both_lines_off;
					next_cur.nonrem = decode_ports(cur.lv_s2[2]);
					next_cur.chg    = decode_ports(cur.lv_s2[3]);
				end else begin
					next_cur.cnt = cur.cnt + CW'(1);
				end
			end
			st_hold: begin
				// values frozen; only a new external or power-on reset clears them
				if (!cur.ext_sync[1]) begin
					next_cur.phase  = st_wait;
					next_cur.valid  = 1'b0;
					next_cur.mode   = mode_rom_master;
					// back to reset values so no stale setting outlives standby
					next_cur.hs_dis = PORTS'(`STRAP_RST_PORTS);
					next_cur.nonrem = PORTS'(`STRAP_RST_PORTS);
					next_cur.chg    = PORTS'(`STRAP_RST_PORTS);
				end
			end
			default: next_cur.phase = st_wait;
		endcase
	end

	// state register; power-on reset clears everything
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			// matches st_wait and rom master: an unstrapped board looks like
			// rom master mode with every port enabled
			cur <= '{rst_sync: 2'h0, ext_sync: 2'h0, dp_s1: '0, dp_s2: '0, dm_s1: '0,
				dm_s2: '0, lv_s1: '0, lv_s2: '0, phase: st_wait, cnt: '0,
				valid: 1'b0, mode: mode_rom_master, hs_dis: '0, nonrem: '0, chg: '0};
		end else begin
			cur <= next_cur;
		end
	end

	// outputs straight from captured state
	assign o_cfg_valid         = cur.valid;
	assign o_pin_mode          = cur.mode;
	assign o_boot_next         = (cur.mode == mode_slave_bus) ? next_soc_cfg : next_otp_cfg;
	assign o_port_hs_disable   = cur.hs_dis;
	assign o_port_ss_disable   = cur.hs_dis;
	assign o_port_nonremovable = cur.nonrem;
	assign o_port_charging     = cur.chg;

	// shared pin functions follow the captured mode
	// every data output above is a state flop or a decode of one; the pin selects are thin
	// decodes of those flops, so no strap path reaches a port uncaptured
	assign o_pin41_is_rom_select          = pin_role(cur.valid, cur.mode, mode_rom_master);
	assign o_pin40_is_rom_data_in_pin     = pin_role(cur.valid, cur.mode, mode_rom_master);
	assign o_pin39_is_slave_bus_data_pin  = pin_role(cur.valid, cur.mode, mode_slave_bus);
	assign o_pin38_is_slave_bus_clock_pin = pin_role(cur.valid, cur.mode, mode_slave_bus);
endmodule // hub_strap_sampler

// ---- inc/hub_strap_regs.svh ----
// timing counts and encodings for the strap sampler
`ifndef HUB_STRAP_REGS_SVH
`define HUB_STRAP_REGS_SVH
// clock rate in MHz
`define STRAP_CLK_MHZ          250
// settle time after reset release before capture, in ns
`define STRAP_SETTLE_NS        40
`define STRAP_SETTLE_CYC       ((`STRAP_SETTLE_NS * `STRAP_CLK_MHZ + 999) / 1000)
// analogue level codes from the resistor detector
`define STRAP_LVL_WEAK_DN      2'h0
`define STRAP_LVL_WEAK_UP      2'h1
`define STRAP_LVL_STRONG_DN    2'h2
`define STRAP_LVL_STRONG_UP    2'h3
// reset values of decoded outputs
`define STRAP_RST_PORTS        2'h0
`endif

// ---- inc/hub_strap_pkg.sv ----
// types for the strap sampler
package hub_strap_pkg;
	typedef logic [1:0] level_t;
	typedef enum logic {mode_rom_master, mode_slave_bus} pin_mode_e;
	typedef enum logic {next_otp_cfg, next_soc_cfg} boot_next_e;
endpackage

// ---- test/hub_strap_sampler_chk.sv ----
// assertions on the strap sampler ports
`timescale 1ns/100ps
module hub_strap_sampler_chk import hub_strap_pkg::*; #(parameter int PORTS = 2) (
	// clock, resets and straps
	input wire logic                  i_clk,
	input wire logic                  i_rst_n,
	input wire logic                  i_ext_rst_n,
	input wire hub_strap_pkg::level_t i_rom_data_out_level,
	input wire hub_strap_pkg::level_t i_rom_clock_level,
	input wire hub_strap_pkg::level_t i_nonremovable_port_strap,
	input wire logic [PORTS-1:0]      i_port_dplus_disable_strap,
	input wire logic [PORTS-1:0]      i_port_dminus_disable_strap,
	// decoded outputs
	input wire logic                  o_cfg_valid,
	input wire logic                  o_pin_mode,
	input wire logic                  o_boot_next,
	input wire logic [PORTS-1:0]      o_port_hs_disable,
	input wire logic [PORTS-1:0]      o_port_ss_disable,
	input wire logic [PORTS-1:0]      o_port_nonremovable,
	input wire logic [PORTS-1:0]      o_port_charging,
	input wire logic                  o_pin41_is_rom_select,
	input wire logic                  o_pin39_is_slave_bus_data_pin
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// straps only equal the inputs at the rise; inputs move freely later
	AST_SS: assert property (o_port_ss_disable == o_port_hs_disable)
		else $error("superspeed disable differs");
	AST_BOOT: assert property (o_boot_next == o_pin_mode)
		else $error("boot stage wrong");
	AST_PIN: assert property (o_pin39_is_slave_bus_data_pin == (o_cfg_valid && o_pin_mode))
		else $error("pin function wrong");
	AST_ROM: assert property (o_pin41_is_rom_select == (o_cfg_valid && !o_pin_mode))
		else $error("rom select wrong");
	AST_MODE: assert property ($rose(o_cfg_valid) |->
		o_pin_mode == ((i_rom_data_out_level & i_rom_clock_level) == 2'h3))
		else $error("mode wrong");
	AST_HS: assert property ($rose(o_cfg_valid) |->
		o_port_hs_disable == (i_port_dplus_disable_strap & i_port_dminus_disable_strap))
		else $error("port disable wrong");
	AST_HOLD: assert property (o_cfg_valid && $past(o_cfg_valid) |->
		$stable({o_pin_mode, o_port_hs_disable, o_port_nonremovable, o_port_charging}))
		else $error("settings moved");
	AST_EXT: assert property ($fell(i_ext_rst_n) |-> ##[1:5] !o_cfg_valid)
		else $error("no restart");
endmodule // hub_strap_sampler_chk

// ---- test/strap_board.sv ----
// board strap resistors feeding the sampler
`timescale 1ns/100ps
module strap_board (
	input  wire logic        i_clk,
	input  wire logic [11:0] i_set,
	output logic      [11:0] o_strap
);
	// resistors settle a cycle after the bench picks them
	always_ff @(posedge i_clk) o_strap <= i_set;
	// rom-mode settings assume a rom holding the signature; rom not modelled
endmodule // strap_board

// ---- test/hub_strap_sampler_tb.sv ----
// self-checking bench for the strap sampler
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
	$display("mismatch %0t %h %h", $time, a, e); end end
module hub_strap_sampler_tb;
	logic        clk = 0, rst_n = 0, ext_n = 1, valid, mode, boot;
	logic [11:0] set = 12'hF5A, s;
	logic [1:0]  hs, ss, nr, ch;
	logic [3:0]  pin;
	int          n_errors = 0, n_tests = 0, cyc = 0;
	always #2 clk = ~clk;
	// cut a hang short
	always @(posedge clk) if (++cyc == 3000) begin n_errors++; summarize(); end
	strap_board u_board (.i_clk(clk), .i_set(set), .o_strap(s));
	hub_strap_sampler u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_ext_rst_n(ext_n),
		.i_rom_data_out_level(s[11:10]), .i_rom_clock_level(s[9:8]),
		.i_nonremovable_port_strap(s[7:6]), .i_charging_port_strap(s[5:4]),
		.i_port_dplus_disable_strap(s[3:2]), .i_port_dminus_disable_strap(s[1:0]),
		.o_cfg_valid(valid), .o_pin_mode(mode), .o_boot_next(boot),
		.o_port_hs_disable(hs), .o_port_ss_disable(ss), .o_port_nonremovable(nr),
		.o_port_charging(ch), .o_pin41_is_rom_select(pin[3]),
		.o_pin40_is_rom_data_in_pin(pin[2]), .o_pin39_is_slave_bus_data_pin(pin[1]),
		.o_pin38_is_slave_bus_clock_pin(pin[0]));
	// strong pull-up is no legal setting on three-level straps
	function automatic logic [1:0] dec(logic [1:0] l);
		return (l == 2'h2) ? 2'h3 : (l == 2'h1) ? 2'h1 : 2'h0;
	endfunction
	task automatic check(input logic [11:0] v);
		logic e;
		e = (v[11:10] & v[9:8]) == 2'h3;
		for (int w = 0; valid !== 1'b1 && w < 40; w++) @(posedge clk);
		#1 `CHK(valid, 1'b1)
		`CHK(mode, e)
		`CHK(boot, e)
		`CHK(pin, e ? 4'h3 : 4'hC)
		`CHK(hs, v[3:2] & v[1:0])
		`CHK(ss, v[3:2] & v[1:0])
		`CHK(nr, dec(v[7:6]))
		`CHK(ch, dec(v[5:4]))
	endtask
	task automatic cap(input logic [11:0] v);
		@(posedge clk) ext_n <= 0;
		set <= v;
		repeat (4) @(posedge clk);
		`CHK(valid, 1'b0)
		ext_n <= 1;
		check(v);
	endtask
	// every level pair and every disable pattern
	task automatic t_codes();
		for (int i = 0; i < 16; i++) cap({3{i[3:0]}});
	endtask
	// external reset again during settle: first straps never captured
	task automatic t_restart();
		@(posedge clk) ext_n <= 0;
		set <= 12'h555;
		repeat (4) @(posedge clk);
		ext_n <= 1;
		repeat (8) @(posedge clk);
		ext_n <= 0;
		set <= 12'hA0F;
		repeat (12) @(posedge clk);
		`CHK(valid, 1'b0)
		ext_n <= 1;
		check(12'hA0F);
	endtask
	// later pin activity must not leak into the settings
	task automatic t_hold();
		cap(12'hF6F);
		@(posedge clk) set <= 12'h090;
		repeat (20) @(posedge clk);
		check(12'hF6F);
	endtask
	task automatic t_por();
		@(posedge clk) rst_n <= 0;
		set <= 12'h2A5;
		#1 `CHK(valid, 1'b0)
		repeat (2) @(posedge clk);
		rst_n <= 1;
		check(12'h2A5);
	endtask
	task automatic summarize();
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1;
		check(12'hF5A);
		t_codes();
		t_restart();
		t_hold();
		t_por();
		summarize();
	end
endmodule // hub_strap_sampler_tb
bind hub_strap_sampler hub_strap_sampler_chk #(.PORTS(PORTS)) u_chk (.*);
